/* verilog/mpio_port_block.sv */
`default_nettype none
// Summary of operation
// R1: Direction/output bit pairs give hi-Z, pull-up input, drive low, drive high.
// R2: Ports C, G, L each have direction, output and pin-read locations.
// R3: Every bit of C, G, L is configured independently by software; the code fixes the G1, G6 and G7 pin functions instead.
// R4: All L pins feed wakeup; L4 and L5 feed timer two inputs.
// R5: G0,G2-G5 bidirectional, G6 input, G1 error out, G7 clock or input.
// R6: In RC option G7 is an input and its rising edge wakes halt.
// R7: Reads of G output bits 6 and 7 return zero.
// R8: Writing one to G output bit 7 requests halt.
// R9: Writing one to G output bit 6 requests idle.
// R10: G direction bit 6 selects alternate serial shift clock phase.
// R11: G direction bit 7 enables halt-exit clock delay in RC option.
// R12: G pins route interrupt, timer one, serial out, clock and in.
// R13: Port I is an 8-bit input-only port shared with analog inputs.
// R14: Port D is output-only and forced high during reset.
// R15: Port D writes reach pins one cycle later than other ports.
// R16: External interrupt driver holds each level one instruction cycle.
// R17: Timer input driver holds each level one instruction cycle.
// R18: Reset clears L, G, C registers so pins float, except G1; the code floats G1 as well during reset.
// R19: Pin-read writes are ignored; reads return current sampled levels.
// R20: Alternate outputs on G still obey the pin's direction bit.
module mpio_port_block
    import mpio_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              srst_i,
    input  wire mpio_bus_s         bus_i,
    output var  logic [DATA_W-1:0] rdata_o,
    output var  logic              rvalid_o,
    input  wire logic [DATA_W-1:0] port_l_i,
    output var  mpio_pin_s         port_l_o,
    input  wire logic [DATA_W-1:0] port_c_i,
    output var  mpio_pin_s         port_c_o,
    input  wire logic [DATA_W-1:0] port_g_i,
    output var  mpio_pin_s         port_g_o,
    input  wire logic [DATA_W-1:0] port_i_i,
    output var  logic [DATA_W-1:0] port_d_o,
    input  wire logic              rc_osc_option_i,
    input  wire logic              osc_clock_i,
    input  wire logic              supervision_error_n_i,
    input  wire logic              timer_one_io_out_i,
    input  wire logic              timer_one_io_en_i,
    input  wire logic              serial_data_out_i,
    input  wire logic              serial_data_out_en_i,
    input  wire logic              serial_shift_clock_out_i,
    input  wire logic              serial_shift_clock_en_i,
    output var  logic [DATA_W-1:0] multi_input_wakeup_o,
    output var  logic              timer_two_input_a_o,
    output var  logic              timer_two_input_b_o,
    output var  logic              external_interrupt_input_o,
    output var  logic              timer_one_capture_in_o,
    output var  logic              timer_one_io_in_o,
    output var  logic              serial_shift_clock_in_o,
    output var  logic              serial_data_in_o,
    output var  logic              shift_clock_phase_select_o,
    output var  logic              halt_exit_clock_delay_o,
    output var  logic              halt_request_o,
    output var  logic              idle_request_o,
    output var  logic              halt_wake_o
);

    function automatic mpio_pin_s pin_decode(input logic [DATA_W-1:0] dir,
                                             input logic [DATA_W-1:0] data);
        mpio_pin_s p;
        p.oe      = dir;
        p.out     = dir & data;
        p.pull_up = ~dir & data;
        return p;
    endfunction

    logic [DATA_W-1:0] dir_l;
    logic [DATA_W-1:0] data_l;
    logic [DATA_W-1:0] dir_c;
    logic [DATA_W-1:0] data_c;
    logic [DATA_W-1:0] dir_g;
    logic [DATA_W-1:0] data_g;
    logic [DATA_W-1:0] data_d;
    logic [DATA_W-1:0] port_d_lag;
    logic [DATA_W-1:0] l_meta;
    logic [DATA_W-1:0] l_sync;
    logic [DATA_W-1:0] c_meta;
    logic [DATA_W-1:0] c_sync;
    logic [DATA_W-1:0] g_meta;
    logic [DATA_W-1:0] g_sync;
    logic [DATA_W-1:0] i_meta;
    logic [DATA_W-1:0] i_sync;
    logic [1:0]        misc_meta;
    logic [1:0]        misc_sync;
    logic              g7_prev;
    logic              rc_mode;
    logic              osc_sync;
    logic              wr_hit;
    mpio_pin_s         next_port_g;

    assign rc_mode  = misc_sync[0];
    assign osc_sync = misc_sync[1];
    assign wr_hit   = bus_i.wr;

    // Two-stage synchronisers for every pin input
    always_ff @(posedge sys_clk_i) begin
        l_meta    <= port_l_i;
        l_sync    <= l_meta;
        c_meta    <= port_c_i;
        c_sync    <= c_meta;
        g_meta    <= port_g_i;
        g_sync    <= g_meta;
        i_meta    <= port_i_i; // R13
        i_sync    <= i_meta;
        misc_meta <= {osc_clock_i, rc_osc_option_i};
        misc_sync <= misc_meta;
    end

    // Port L and C registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            dir_l  <= PORT_RST; // R18
            data_l <= PORT_RST;
            dir_c  <= PORT_RST;
            data_c <= PORT_RST;
        end else if (wr_hit) begin
            if (bus_i.addr == L_DATA_ADDR) begin // R2 R3
                data_l <= bus_i.wdata;
            end else if (bus_i.addr == L_DIR_ADDR) begin
                dir_l <= bus_i.wdata;
            end else if (bus_i.addr == C_DATA_ADDR) begin
                data_c <= bus_i.wdata;
            end else if (bus_i.addr == C_DIR_ADDR) begin
                dir_c <= bus_i.wdata;
            end
        end
    end

    // Port G registers; data bits 6 and 7 are never stored
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            dir_g  <= PORT_RST; // R18
            data_g <= PORT_RST;
        end else if (wr_hit) begin
            if (bus_i.addr == G_DATA_ADDR) begin
                data_g <= bus_i.wdata & G_DATA_MASK; // R7
            end else if (bus_i.addr == G_DIR_ADDR) begin
                dir_g <= bus_i.wdata;
            end
        end
    end

    // Port D register and its extra pipeline stage
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            data_d     <= PORT_D_RST; // R14
            port_d_lag <= PORT_D_RST;
            port_d_o   <= PORT_D_RST;
        end else begin
            if (wr_hit && bus_i.addr == D_DATA_ADDR) begin
                data_d <= bus_i.wdata;
            end
            port_d_lag <= data_d; // R15
            port_d_o   <= port_d_lag;
        end
    end

    // Port G pin drive with alternate functions
    always_comb begin
        next_port_g = pin_decode(dir_g, data_g); // R1 R5
        if (timer_one_io_en_i) begin
            next_port_g.out[G_T1IO_BIT] = dir_g[G_T1IO_BIT] & timer_one_io_out_i; // R12 R20
        end
        if (serial_data_out_en_i) begin
            next_port_g.out[G_SO_BIT] = dir_g[G_SO_BIT] & serial_data_out_i; // R12 R20
        end
        if (serial_shift_clock_en_i) begin
            next_port_g.out[G_SK_BIT] = dir_g[G_SK_BIT] & serial_shift_clock_out_i; // R20
        end
        next_port_g.out[G_ERR_BIT]     = 1'b0; // R5 R18
        next_port_g.oe[G_ERR_BIT]      = ~supervision_error_n_i;
        next_port_g.pull_up[G_ERR_BIT] = 1'b0;
        next_port_g.out[G_SI_BIT]      = 1'b0; // R5
        next_port_g.oe[G_SI_BIT]       = 1'b0;
        next_port_g.pull_up[G_SI_BIT]  = 1'b0;
        next_port_g.out[G_CKO_BIT]     = ~rc_mode & osc_sync; // R6
        next_port_g.oe[G_CKO_BIT]      = ~rc_mode;
        next_port_g.pull_up[G_CKO_BIT] = 1'b0;
    end

    // Registered pin drive for L, C, G
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            port_l_o <= '0;
            port_c_o <= '0;
            port_g_o <= '0;
        end else begin
            port_l_o <= pin_decode(dir_l, data_l); // R1 R3
            port_c_o <= pin_decode(dir_c, data_c); // R1 R3
            port_g_o <= next_port_g;
        end
    end

    // Alternate input functions
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            multi_input_wakeup_o       <= '0;
            timer_two_input_a_o        <= 1'b0;
            timer_two_input_b_o        <= 1'b0;
            external_interrupt_input_o <= 1'b0;
            timer_one_capture_in_o     <= 1'b0;
            timer_one_io_in_o          <= 1'b0;
            serial_shift_clock_in_o    <= 1'b0;
            serial_data_in_o           <= 1'b0;
        end else begin
            multi_input_wakeup_o       <= l_sync; // R4
            timer_two_input_a_o        <= l_sync[L_T2A_BIT]; // R4 R17
            timer_two_input_b_o        <= l_sync[L_T2B_BIT]; // R4 R17
            external_interrupt_input_o <= g_sync[G_EXTERNAL_INTERRUPT_INPUT_BIT]; // R12 R16
            timer_one_capture_in_o     <= g_sync[G_CAP_BIT]; // R12
            timer_one_io_in_o          <= g_sync[G_T1IO_BIT]; // R12
            serial_shift_clock_in_o    <= g_sync[G_SK_BIT]; // R12
            serial_data_in_o           <= g_sync[G_SI_BIT]; // R12
        end
    end

    // Special-purpose controls in port G bits 6 and 7
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            shift_clock_phase_select_o <= 1'b0;
            halt_exit_clock_delay_o    <= 1'b0;
            halt_request_o             <= 1'b0;
            idle_request_o             <= 1'b0;
            halt_wake_o                <= 1'b0;
            g7_prev                    <= g_sync[G_CKO_BIT];
        end else begin
            shift_clock_phase_select_o <= dir_g[G_PHASE_BIT]; // R10
            halt_exit_clock_delay_o    <= dir_g[G_DLY_BIT] & rc_mode; // R11
            halt_request_o <= wr_hit && bus_i.addr == G_DATA_ADDR
                              && bus_i.wdata[G_HALT_BIT]; // R8
            idle_request_o <= wr_hit && bus_i.addr == G_DATA_ADDR
                              && bus_i.wdata[G_IDLE_BIT]; // R9
            g7_prev     <= g_sync[G_CKO_BIT];
            halt_wake_o <= rc_mode & g_sync[G_CKO_BIT] & ~g7_prev; // R6
        end
    end

    // Register reads
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_o  <= READ_IDLE;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= bus_i.rd;
            if (!bus_i.rd) begin
                rdata_o <= READ_IDLE;
            end else if (bus_i.addr == L_DATA_ADDR) begin
                rdata_o <= data_l;
            end else if (bus_i.addr == L_DIR_ADDR) begin
                rdata_o <= dir_l;
            end else if (bus_i.addr == L_PIN_ADDR) begin
                rdata_o <= l_sync; // R19
            end else if (bus_i.addr == G_DATA_ADDR) begin
                rdata_o <= data_g & G_DATA_MASK; // R7
            end else if (bus_i.addr == G_DIR_ADDR) begin
                rdata_o <= dir_g;
            end else if (bus_i.addr == G_PIN_ADDR) begin
                rdata_o <= g_sync; // R19
            end else if (bus_i.addr == I_PIN_ADDR) begin
                rdata_o <= i_sync; // R13
            end else if (bus_i.addr == C_DATA_ADDR) begin
                rdata_o <= data_c;
            end else if (bus_i.addr == C_DIR_ADDR) begin
                rdata_o <= dir_c;
            end else if (bus_i.addr == C_PIN_ADDR) begin
                rdata_o <= c_sync; // R19
            end else if (bus_i.addr == D_DATA_ADDR) begin
                rdata_o <= data_d;
            end else begin
                rdata_o <= READ_IDLE;
            end
        end
    end

    // Checks
    decode_l_pins_a: // R1
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !$past(srst_i) |-> port_l_o.oe == $past(dir_l)
            && port_l_o.out == ($past(dir_l) & $past(data_l))
            && port_l_o.pull_up == (~$past(dir_l) & $past(data_l)))
        else $error("Port L pin drive does not match its registers");

    pin_write_ignored_a: // R19
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        bus_i.wr && bus_i.addr == L_PIN_ADDR |=> $stable(dir_l) && $stable(data_l))
        else $error("Write to pin location changed port L");

    g_high_read_zero_a: // R7
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        bus_i.rd && bus_i.addr == G_DATA_ADDR |=> rvalid_o && rdata_o[7:6] == 2'b00)
        else $error("Port G output bits 6 and 7 read nonzero");

    halt_request_a: // R8
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        bus_i.wr && bus_i.addr == G_DATA_ADDR && bus_i.wdata[G_HALT_BIT]
            |=> halt_request_o ##1 !halt_request_o || $past(bus_i.wr))
        else $error("Halt request missing after write");

    idle_request_a: // R9
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        idle_request_o |-> $past(bus_i.wr) && $past(bus_i.addr) == G_DATA_ADDR)
        else $error("Idle request without a port G write");

    phase_select_a: // R10
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        bus_i.wr && bus_i.addr == G_DIR_ADDR |=> ##1
            shift_clock_phase_select_o == $past(bus_i.wdata[G_PHASE_BIT], 2))
        else $error("Shift clock phase does not follow direction bit 6");

    g6_input_only_a: // R5
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !port_g_o.oe[G_SI_BIT])
        else $error("G6 is driven");

    port_d_lag_a: // R15
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !$past(srst_i) && !$past(srst_i, 2) |-> port_d_o == $past(data_d, 2))
        else $error("Port D does not lag its register by two cycles");

    port_d_reset_a: // R14
    assert property (@(posedge sys_clk_i) disable iff (1'b0)
        srst_i |=> port_d_o == PORT_D_RST)
        else $error("Port D not high after reset");

    reset_float_a: // R18
    assert property (@(posedge sys_clk_i) disable iff (1'b0)
        srst_i ##1 srst_i |=> port_l_o.oe == '0 && port_c_o.oe == '0
            && port_g_o.oe[5:2] == 4'h0)
        else $error("Ports not floating after reset");

    wake_rc_only_a: // R6
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        halt_wake_o |-> $past(rc_mode) && $past(g_sync[G_CKO_BIT]) && !$past(g7_prev))
        else $error("Halt wake without G7 rising edge in RC mode");

    clock_delay_a: // R11
    assert property (@(posedge sys_clk_i) disable iff (srst_i)
        halt_exit_clock_delay_o |-> $past(rc_mode) && $past(dir_g[G_DLY_BIT]))
        else $error("Clock delay enabled outside RC mode");

endmodule // mpio_port_block
`default_nettype wire

/* verilog/mpio_pkg.sv */
`default_nettype none
package mpio_pkg;

    // Data-memory bus and port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Data-memory locations of the port registers
    localparam logic [ADDR_W-1:0] L_DATA_ADDR = 8'hd0;
    localparam logic [ADDR_W-1:0] L_DIR_ADDR  = 8'hd1;
    localparam logic [ADDR_W-1:0] L_PIN_ADDR  = 8'hd2;
    localparam logic [ADDR_W-1:0] G_DATA_ADDR = 8'hd4;
    localparam logic [ADDR_W-1:0] G_DIR_ADDR  = 8'hd5;
    localparam logic [ADDR_W-1:0] G_PIN_ADDR  = 8'hd6;
    localparam logic [ADDR_W-1:0] I_PIN_ADDR  = 8'hd7;
    localparam logic [ADDR_W-1:0] C_DATA_ADDR = 8'hd8;
    localparam logic [ADDR_W-1:0] C_DIR_ADDR  = 8'hd9;
    localparam logic [ADDR_W-1:0] C_PIN_ADDR  = 8'hda;
    localparam logic [ADDR_W-1:0] D_DATA_ADDR = 8'hdc;

    // Reset values
    localparam logic [DATA_W-1:0] PORT_RST   = 8'h00;
    localparam logic [DATA_W-1:0] PORT_D_RST = 8'hff;
    localparam logic [DATA_W-1:0] READ_IDLE  = 8'h00;

    // Port G special bits
    localparam int G_EXTERNAL_INTERRUPT_INPUT_BIT  = 0;
    localparam int G_ERR_BIT   = 1;
    localparam int G_CAP_BIT   = 2;
    localparam int G_T1IO_BIT  = 3;
    localparam int G_SO_BIT    = 4;
    localparam int G_SK_BIT    = 5;
    localparam int G_SI_BIT    = 6;
    localparam int G_IDLE_BIT  = 6;
    localparam int G_HALT_BIT  = 7;
    localparam int G_PHASE_BIT = 6;
    localparam int G_DLY_BIT   = 7;
    localparam int G_CKO_BIT   = 7;
    localparam logic [DATA_W-1:0] G_DATA_MASK = 8'h3f;

    // Port L timer-two inputs
    localparam int L_T2A_BIT = 4;
    localparam int L_T2B_BIT = 5;

    typedef struct packed {
        logic [DATA_W-1:0] out;
        logic [DATA_W-1:0] oe;
        logic [DATA_W-1:0] pull_up;
    } mpio_pin_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } mpio_bus_s;

endpackage
`default_nettype wire

/* dv/mpio_board.sv */
`default_nettype none
module mpio_board
    import mpio_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire mpio_pin_s         pin_i,
    input  wire logic [DATA_W-1:0] ext_val_i,
    input  wire logic [DATA_W-1:0] ext_en_i,
    output var  logic [DATA_W-1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip;
    initial flip = 1'b0;
    // Undriven pins without pull-up wander every cycle
    always @(posedge sys_clk_i) begin
        flip <= ~flip;
    end
    // Design drive wins, then board drive, then weak pull-up
    always_comb begin
        for (int b = 0; b < DATA_W; b++) begin
            if (pin_i.oe[b])
                level_o[b] = pin_i.out[b];
            else if (ext_en_i[b])
                level_o[b] = ext_val_i[b];
            else if (pin_i.pull_up[b])
                level_o[b] = 1'b1;
            else
                level_o[b] = flip ^ b[0];
        end
    end
endmodule // mpio_board
`default_nettype wire

/* dv/mpio_port_block_tb.sv */
`default_nettype none
module mpio_port_block_tb
    import mpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, srst, rvalid, rc, err_n, t1o, t1e, osc;
    logic       t2a, t2b, external_interrupt_input, cap, t1i, ski, si, phase, dly, halt, idle, wake;
    mpio_bus_s  bus;
    mpio_pin_s  lo, co, go;
    logic [7:0] rdata, lv, cv, gv, pi, pd, multi_input_wakeup, l_val, l_en, c_val, c_en, g_val, g_en;
    logic [7:0] d, dr, lx, gx;
    logic [7:0] expq[$];
    int         errors, checked, seed, cyc, hits, pos;

    mpio_port_block dut (.sys_clk_i(clk), .srst_i(srst), .bus_i(bus), .rdata_o(rdata),
        .rvalid_o(rvalid), .port_l_i(lv), .port_l_o(lo), .port_c_i(cv), .port_c_o(co),
        .port_g_i(gv), .port_g_o(go), .port_i_i(pi), .port_d_o(pd), .rc_osc_option_i(rc),
        .osc_clock_i(osc), .supervision_error_n_i(err_n), .timer_one_io_out_i(t1o),
        .timer_one_io_en_i(t1e), .serial_data_out_i(t1o), .serial_data_out_en_i(t1e),
        .serial_shift_clock_out_i(t1o), .serial_shift_clock_en_i(t1e),
        .multi_input_wakeup_o(multi_input_wakeup), .timer_two_input_a_o(t2a), .timer_two_input_b_o(t2b),
        .external_interrupt_input_o(external_interrupt_input), .timer_one_capture_in_o(cap),
        .timer_one_io_in_o(t1i), .serial_shift_clock_in_o(ski), .serial_data_in_o(si),
        .shift_clock_phase_select_o(phase), .halt_exit_clock_delay_o(dly),
        .halt_request_o(halt), .idle_request_o(idle), .halt_wake_o(wake));
    mpio_board brd_l (.sys_clk_i(clk), .pin_i(lo), .ext_val_i(l_val), .ext_en_i(l_en),
        .level_o(lv));
    mpio_board brd_c (.sys_clk_i(clk), .pin_i(co), .ext_val_i(c_val), .ext_en_i(c_en),
        .level_o(cv));
    mpio_board brd_g (.sys_clk_i(clk), .pin_i(go), .ext_val_i(g_val), .ext_en_i(g_en),
        .level_o(gv));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pins(string p, mpio_pin_s got, logic [7:0] dir, logic [7:0] dat,
                        logic [7:0] m);
        cmp({p, " oe"}, dir & m, got.oe);
        cmp({p, " out"}, dir & dat & m, got.out);
        cmp({p, " pull"}, ~dir & dat & m, got.pull_up);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(negedge clk);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(negedge clk);
        bus.wr    <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        expq.push_back(e);
        @(negedge clk);
        bus.rd   <= 1'b0;
    endtask

    task automatic reset_chk(int n);
        srst = 1'b1;
        repeat (n) @(negedge clk);
        pins("L", lo, 8'h00, 8'h00, 8'hff);
        pins("C", co, 8'h00, 8'h00, 8'hff);
        pins("G", go, 8'h00, 8'h00, 8'hff);
        cmp("port D", 8'hff, pd);
        srst = 1'b0;
    endtask

    // Read results are checked in the cycle that rvalid stands
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (expq.size() == 0)
                cmp("stray read", 8'h00, 8'hff);
            else
                cmp("read data", expq.pop_front(), rdata);
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            $display("[ERR] timeout expected done seen hang");
            summarize();
        end
    end

    initial begin
        srst = 1'b1; bus = '0; pi = 8'h00; rc = 1'b1; err_n = 1'b1; t1o = 1'b0; t1e = 1'b0;
        l_val = 8'h00; l_en = 8'hff; c_val = 8'h00; c_en = 8'hff; g_val = 8'h00; osc = 1'b0;
        g_en = 8'hff; errors = 0; checked = 0; seed = 35302; cyc = 0;
        reset_chk(20);
        for (int k = 0; k < 4; k++) begin
            d  = (k == 0) ? 8'h55 : 8'($random(seed));
            dr = (k == 0) ? 8'h33 : 8'($random(seed));
            l_en = ~dr; c_en = dr; g_en = ~(dr & 8'h3d);
            l_val = 8'($random(seed)); c_val = 8'($random(seed)); g_val = 8'($random(seed));
            pi = 8'($random(seed));
            wr(L_DIR_ADDR, dr);
            wr(L_DATA_ADDR, d);
            wr(C_DIR_ADDR, ~dr);
            wr(C_DATA_ADDR, d);
            wr(G_DIR_ADDR, dr);
            wr(G_DATA_ADDR, d & 8'h3f);
            wr(L_PIN_ADDR, ~d);
            wr(8'hdf, 8'hff);
            repeat (4) @(negedge clk);
            lx = (dr & d) | (~dr & l_val);
            gx = (dr & d & 8'h3d) | (~(dr & 8'h3d) & g_val);
            pins("L", lo, dr, d, 8'hff);
            pins("C", co, ~dr, d, 8'hff);
            pins("G", go, dr, d, 8'h3d);
            cmp("wakeup", lx, multi_input_wakeup);
            cmp("timer two", {6'h0, lx[5], lx[4]}, {6'h0, t2b, t2a});
            cmp("g alt in", {3'h0, gx[6], gx[5], gx[3:2], gx[0]},
                {3'h0, si, ski, t1i, cap, external_interrupt_input});
            cmp("phase dly", {6'h0, dr[7], dr[6]}, {6'h0, dly, phase});
            rd(L_DIR_ADDR, dr);
            rd(L_DATA_ADDR, d);
            rd(L_PIN_ADDR, lx);
            rd(C_PIN_ADDR, (~dr & d) | (dr & c_val));
            rd(G_PIN_ADDR, gx);
            rd(G_DIR_ADDR, dr);
            rd(I_PIN_ADDR, pi);
            rd(8'hdf, 8'h00);
        end
        // Halt and idle requests, bits read back as zero
        for (int k = 0; k < 2; k++) begin
            wr(G_DATA_ADDR, (k == 0) ? 8'h8a : 8'h45);
            cmp("halt idle", (k == 0) ? 8'h02 : 8'h01, {6'h0, halt, idle});
            @(negedge clk);
            cmp("halt idle end", 8'h00, {6'h0, halt, idle});
            rd(G_DATA_ADDR, (k == 0) ? 8'h0a : 8'h05);
        end
        // Port D lags other ports by one cycle
        wr(D_DATA_ADDR, 8'h5a);
        @(negedge clk);
        cmp("port D early", 8'hff, pd);
        @(negedge clk);
        cmp("port D", 8'h5a, pd);
        // Alternate output obeys direction bit
        t1e = 1'b1; t1o = 1'b1; g_en = 8'hff;
        wr(G_DIR_ADDR, 8'h00);
        wr(G_DATA_ADDR, 8'h00);
        repeat (4) @(negedge clk);
        cmp("g alt float", 8'h00, {2'h0, go.oe[5:3], go.out[5:3]});
        g_en = 8'hc7;
        wr(G_DIR_ADDR, 8'h38);
        repeat (4) @(negedge clk);
        cmp("g alt drive", 8'h3f, {2'h0, go.oe[5:3], go.out[5:3]});
        t1e = 1'b0; err_n = 1'b0;
        repeat (4) @(negedge clk);
        cmp("g1 error", 8'h02, {6'h0, go.oe[1], go.out[1]});
        err_n = 1'b1; rc = 1'b0; osc = 1'b1;
        wr(G_DIR_ADDR, 8'h80);
        repeat (4) @(negedge clk);
        cmp("crystal", 8'h03, {5'h0, dly, go.oe[7], go.out[7]});
        // Rising G7 in RC option wakes from halt
        rc = 1'b1; g_val = 8'h00;
        repeat (5) @(negedge clk);
        g_val = 8'h80; hits = 0; pos = 0;
        for (int k = 1; k < 7; k++) begin
            @(negedge clk);
            if (wake === 1'b1) begin
                hits++;
                pos = k;
            end
        end
        cmp("wake pulses", 8'd1, 8'(hits));
        cmp("wake cycle", 8'd3, 8'(pos));
        reset_chk(3);
        hits = 0;
        repeat (3) begin
            @(negedge clk);
            if (wake !== 1'b0)
                hits++;
        end
        cmp("wake after reset", 8'd0, 8'(hits));
        summarize();
    end
endmodule // mpio_port_block_tb
`default_nettype wire
